// ==== core/adcsc_top.sv ====
// conversion sequencing, sleep handling and register file of the converter control
//
// Added by the designer: the strobed register port.
`include "adcsc_defines.svh"
module adcsc_top
  import adcsc_pkg::*;
(
  input wire logic core_clk, // 250 mhz clock
  input wire logic reset, // synchronous, active high
  input wire logic [7:0] addr, // register address
  input wire logic [7:0] wdata, // write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  input wire logic sleep_exec, // pulse: sleep instruction executed
  input wire logic [11:0] sample_code, // code from the analog front end
  output logic [7:0] rdata, // read data, cycle after rd
  output logic core_asleep, // core held in sleep
  output logic wake_pulse, // one-cycle wake request
  output logic vector_load, // pulse: load program counter with vector
  output logic [12:0] program_counter, // vector value with vector_load
  output logic converter_active, // analog part powered and running
  output logic irq // level, unmasked event pending
);
  typedef struct packed {
    adcsc_phase_e phase;
    logic [7:0] ctrl0;
    logic [7:0] ctrl1;
    logic [7:0] vref;
    logic [7:0] irq_ctrl;
    logic [7:0] pflags;
    logic [7:0] penables;
    logic [7:0] res_hi;
    logic [7:0] res_lo;
    logic [7:0] ev_status;
    logic [7:0] ev_mask;
    logic [7:0] div_cnt;
    logic [3:0] bit_cnt;
    logic [2:0] delay_cnt;
    logic asleep;
    logic wake;
    logic vload;
    logic active;
    logic [7:0] rdata;
    logic irq;
    logic [12:0] pc;
  } adcsc_state_s;

  adcsc_state_s q;
  adcsc_state_s d;

  // conversion clock terminal count for each select value
  function automatic logic [7:0] adcsc_div_limit(input logic [1:0] sel);
    case (adcsc_clk_sel_e'(sel))
      ADCSC_CLK_DIV2: adcsc_div_limit = `ADCSC_DIV2_LIMIT;
      ADCSC_CLK_DIV8: adcsc_div_limit = `ADCSC_DIV8_LIMIT;
      ADCSC_CLK_DIV32: adcsc_div_limit = `ADCSC_DIV32_LIMIT;
      default: adcsc_div_limit = `ADCSC_RC_DIV - 8'h01;
    endcase
  endfunction : adcsc_div_limit

  logic rc_sel;
  logic done_evt;
  logic wake_en;
  logic [15:0] left_result;
  logic [2:0] ev_new;

  assign rc_sel = (q.ctrl0[`ADCSC_CLK_SEL_HI:`ADCSC_CLK_SEL_LO] == 2'h3);
  // result layout follows the format bit: left or right justified 12 bits
  assign left_result = q.ctrl1[7] ? {4'h0, sample_code} : {sample_code, 4'h0};

  always_comb begin
    d = q;
    d.wake = 1'b0;
    d.vload = 1'b0;
    done_evt = 1'b0;
    ev_new = 3'h0;
    wake_en = q.penables[`ADCSC_CONV_DONE_BIT] & q.irq_ctrl[`ADCSC_PERIPH_IRQ_EN_BIT];
    // conversion sequencer
    case (q.phase)
      ADCSC_IDLE: begin
        d.active = 1'b0;
        if (q.ctrl0[`ADCSC_CONV_START_BIT] && q.ctrl0[`ADCSC_CONV_POWER_BIT]) begin
          d.div_cnt = 8'h00;
          d.bit_cnt = 4'h0;
          d.delay_cnt = 3'h0;
          d.phase = rc_sel ? ADCSC_DELAY : ADCSC_CONVERT;
          d.active = ~rc_sel;
        end
      end
      ADCSC_DELAY: begin
        // gives the sleep instruction time to quiet the core before sampling
        d.delay_cnt = q.delay_cnt + 3'h1;
        if (q.delay_cnt == `ADCSC_INSTR_CYCLE_CLKS - 3'h1) begin
          d.phase = ADCSC_CONVERT;
          d.active = 1'b1;
        end
      end
      ADCSC_CONVERT: begin
        if (q.div_cnt == adcsc_div_limit(q.ctrl0[`ADCSC_CLK_SEL_HI:`ADCSC_CLK_SEL_LO])) begin
          d.div_cnt = 8'h00;
          d.bit_cnt = q.bit_cnt + 4'h1;
          if (q.bit_cnt == `ADCSC_CONV_BITS - 4'h1) begin
            done_evt = 1'b1;
            d.phase = ADCSC_IDLE;
            d.active = 1'b0;
            d.ctrl0[`ADCSC_CONV_START_BIT] = 1'b0;
            d.res_hi = left_result[15:8];
            d.res_lo = left_result[7:0];
            d.pflags[`ADCSC_CONV_DONE_BIT] = 1'b1;
            ev_new[`ADCSC_EV_DONE] = 1'b1;
          end
        end else begin
          d.div_cnt = q.div_cnt + 8'h01;
        end
      end
      default: begin
        d.phase = ADCSC_IDLE;
        d.active = 1'b0;
      end
    endcase
    // power bit cleared by software stops everything
    if (!q.ctrl0[`ADCSC_CONV_POWER_BIT]) begin
      d.phase = ADCSC_IDLE;
      d.active = 1'b0;
      d.ctrl0[`ADCSC_CONV_START_BIT] = 1'b0;
    end
    // sleep entry
    if (sleep_exec && !q.asleep) begin
      d.asleep = 1'b1;
      if (!rc_sel && q.phase != ADCSC_IDLE && !done_evt) begin
        d.phase = ADCSC_IDLE;
        d.active = 1'b0;
        d.ctrl0[`ADCSC_CONV_START_BIT] = 1'b0;
        ev_new[`ADCSC_EV_ABORT] = 1'b1;
      end
    end
    // wake only via the done flag; power bit untouched either way
    if (q.asleep && done_evt && wake_en) begin
      d.asleep = 1'b0;
      d.wake = 1'b1;
      d.vload = q.irq_ctrl[`ADCSC_GLOBAL_IRQ_EN_BIT];
      ev_new[`ADCSC_EV_WAKE] = 1'b1;
    end
    // register writes; hardware set of a flag wins over a software clear
    if (wr) begin
      case (addr)
        `ADCSC_OFF_CONV_CTRL0: begin
          d.ctrl0 = wdata;
          if (done_evt && !wdata[`ADCSC_CONV_START_BIT]) begin
            d.ctrl0[`ADCSC_CONV_START_BIT] = 1'b0;
          end else if (done_evt) begin
            d.ctrl0[`ADCSC_CONV_START_BIT] = 1'b1;
          end
        end
        `ADCSC_OFF_CONV_CTRL1: d.ctrl1 = wdata;
        `ADCSC_OFF_VREF_CTRL: d.vref = wdata & `ADCSC_VREF_IMPL_MASK;
        `ADCSC_OFF_CORE_IRQ_CTRL: d.irq_ctrl = wdata;
        `ADCSC_OFF_PERIPH_FLAGS: begin
          d.pflags = wdata;
          if (done_evt) begin
            d.pflags[`ADCSC_CONV_DONE_BIT] = 1'b1;
          end
        end
        `ADCSC_OFF_PERIPH_ENABLES: d.penables = wdata;
        `ADCSC_OFF_RESULT_HIGH: d.res_hi = wdata;
        `ADCSC_OFF_RESULT_LOW: d.res_lo = wdata;
        `ADCSC_OFF_EVENT_MASK: d.ev_mask = wdata & 8'h07;
        default: d.ev_mask = d.ev_mask;
      endcase
    end
    // read data, one cycle later; read of status clears it, new events win
    d.rdata = 8'h00;
    if (rd) begin
      case (addr)
        `ADCSC_OFF_CONV_CTRL0: d.rdata = q.ctrl0;
        `ADCSC_OFF_CONV_CTRL1: d.rdata = q.ctrl1;
        `ADCSC_OFF_VREF_CTRL: d.rdata = q.vref & `ADCSC_VREF_IMPL_MASK;
        `ADCSC_OFF_CORE_IRQ_CTRL: d.rdata = q.irq_ctrl;
        `ADCSC_OFF_PERIPH_FLAGS: d.rdata = q.pflags;
        `ADCSC_OFF_PERIPH_ENABLES: d.rdata = q.penables;
        `ADCSC_OFF_RESULT_HIGH: d.rdata = q.res_hi;
        `ADCSC_OFF_RESULT_LOW: d.rdata = q.res_lo;
        `ADCSC_OFF_EVENT_MASK: d.rdata = q.ev_mask;
        `ADCSC_OFF_EVENT_STATUS: begin
          d.rdata = q.ev_status;
          d.ev_status = 8'h00;
        end
        default: d.rdata = 8'h00;
      endcase
    end
    // events of this cycle land after a read clear, so a set is never lost
    d.ev_status = d.ev_status | {5'h00, ev_new};
    d.irq = |(d.ev_status & d.ev_mask);
    d.pc = d.vload ? `ADCSC_IRQ_VECTOR : 13'h0000;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      q <= '0;
      q.phase <= ADCSC_IDLE;
      q.ctrl0 <= `ADCSC_RESET_VALUE;
      q.ctrl1 <= `ADCSC_RESET_VALUE;
      q.vref <= `ADCSC_RESET_VALUE;
      q.pflags <= `ADCSC_RESET_VALUE;
      q.penables <= `ADCSC_RESET_VALUE;
      // result bytes hold their value through any reset
      q.res_hi <= q.res_hi;
      q.res_lo <= q.res_lo;
    end else begin
      q <= d;
    end
  end

  assign rdata = q.rdata;
  assign core_asleep = q.asleep;
  assign wake_pulse = q.wake;
  assign vector_load = q.vload;
  assign program_counter = q.pc;
  assign converter_active = q.active;
  assign irq = q.irq;

  // assertions
  property p_done_clears_start;
    @(posedge core_clk) disable iff (reset)
      (q.phase == ADCSC_CONVERT && d.phase == ADCSC_IDLE && done_evt) |=> (!q.ctrl0[2] || $past(wr));
  endproperty
  a_done_clears_start: assert property (p_done_clears_start) else $error("start bit not cleared");

  property p_done_flag;
    @(posedge core_clk) disable iff (reset) done_evt |=> q.pflags[6];
  endproperty
  a_done_flag: assert property (p_done_flag) else $error("done flag not set");

  sequence s_rc_start;
    q.phase == ADCSC_IDLE && q.ctrl0[2] && q.ctrl0[0] && rc_sel;
  endsequence
  property p_rc_delay;
    @(posedge core_clk) disable iff (reset)
      s_rc_start |=> (q.phase == ADCSC_DELAY && !q.active)[*4];
  endproperty
  a_rc_delay: assert property (p_rc_delay) else $error("rc start not delayed");

  property p_wake;
    @(posedge core_clk) disable iff (reset)
      (q.asleep && done_evt && wake_en) |=> (wake_pulse && !core_asleep);
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on enabled done");

  property p_stay_asleep;
    @(posedge core_clk) disable iff (reset)
      (q.asleep && done_evt && !wake_en) |=> (core_asleep && q.ctrl0[0] == $past(q.ctrl0[0]));
  endproperty
  a_stay_asleep: assert property (p_stay_asleep) else $error("woke without enable");

  property p_abort;
    @(posedge core_clk) disable iff (reset)
      (sleep_exec && !q.asleep && !rc_sel && q.phase == ADCSC_CONVERT && q.ctrl0[0] && !done_evt && !wr)
        |=> (!converter_active && q.ctrl0[0]);
  endproperty
  a_abort: assert property (p_abort) else $error("conversion not aborted");

  property p_vref_zero;
    @(posedge core_clk) disable iff (reset) q.vref[3:0] == 4'h0;
  endproperty
  a_vref_zero: assert property (p_vref_zero) else $error("vref low bits not zero");

  property p_vector;
    @(posedge core_clk) disable iff (reset) vector_load |-> (program_counter == 13'h0004 && wake_pulse);
  endproperty
  a_vector: assert property (p_vector) else $error("vector not loaded");

  property p_result_load;
    @(posedge core_clk) disable iff (reset)
      (done_evt && !wr) |=> ({q.res_hi, q.res_lo} == $past(left_result));
  endproperty
  a_result_load: assert property (p_result_load) else $error("result not loaded on completion");

  property p_power_off_idle;
    @(posedge core_clk) disable iff (reset)
      !q.ctrl0[0] |=> (q.phase == ADCSC_IDLE && !converter_active);
  endproperty
  a_power_off_idle: assert property (p_power_off_idle) else $error("converter runs with power bit clear");

  // rc clocked conversion survives the sleep instruction
  property p_rc_no_abort;
    @(posedge core_clk) disable iff (reset)
      (sleep_exec && rc_sel && q.phase != ADCSC_IDLE && q.ctrl0[0] && !done_evt && !wr) |=> q.phase != ADCSC_IDLE;
  endproperty
  a_rc_no_abort: assert property (p_rc_no_abort) else $error("rc conversion stopped by sleep");

  property p_rdata_idle;
    @(posedge core_clk) disable iff (reset) !rd |=> rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read cycle");
endmodule : adcsc_top

// ==== core/adcsc_defines.svh ====
// register map, field positions, reset values and timing counts for the sleep-aware converter control
`ifndef ADCSC_DEFINES_SVH
`define ADCSC_DEFINES_SVH
`define ADCSC_OFF_CORE_IRQ_CTRL 8'h0b
`define ADCSC_OFF_PERIPH_FLAGS 8'h0c
`define ADCSC_OFF_RESULT_HIGH 8'h1e
`define ADCSC_OFF_CONV_CTRL0 8'h1f
`define ADCSC_OFF_PERIPH_ENABLES 8'h8c
`define ADCSC_OFF_VREF_CTRL 8'h9b
`define ADCSC_OFF_RESULT_LOW 8'h9e
`define ADCSC_OFF_CONV_CTRL1 8'h9f
`define ADCSC_OFF_EVENT_STATUS 8'hf0
`define ADCSC_OFF_EVENT_MASK 8'hf1
`define ADCSC_GLOBAL_IRQ_EN_BIT 7
`define ADCSC_PERIPH_IRQ_EN_BIT 6
`define ADCSC_PAR_PORT_BIT 7
`define ADCSC_CONV_DONE_BIT 6
`define ADCSC_CONV_START_BIT 2
`define ADCSC_CONV_POWER_BIT 0
`define ADCSC_CLK_SEL_HI 7
`define ADCSC_CLK_SEL_LO 6
`define ADCSC_VREF_IMPL_MASK 8'hf0
`define ADCSC_RESET_VALUE 8'h00
`define ADCSC_INSTR_CYCLE_CLKS 3'h4
`define ADCSC_CONV_BITS 4'hc
`define ADCSC_RC_DIV 8'hfa
`define ADCSC_DIV2_LIMIT 8'h01
`define ADCSC_DIV8_LIMIT 8'h07
`define ADCSC_DIV32_LIMIT 8'h1f
`define ADCSC_IRQ_VECTOR 13'h0004
`define ADCSC_EV_DONE 0
`define ADCSC_EV_WAKE 1
`define ADCSC_EV_ABORT 2
`endif

// ==== core/adcsc_pkg.sv ====
// types shared by the sleep-aware converter control
package adcsc_pkg;
  typedef enum logic [1:0] {
    ADCSC_IDLE = 2'b00,
    ADCSC_DELAY = 2'b01,
    ADCSC_CONVERT = 2'b10
  } adcsc_phase_e;
  typedef enum logic [1:0] {
    ADCSC_CLK_DIV2 = 2'b00,
    ADCSC_CLK_DIV8 = 2'b01,
    ADCSC_CLK_DIV32 = 2'b10,
    ADCSC_CLK_RC = 2'b11
  } adcsc_clk_sel_e;
endpackage : adcsc_pkg

// ==== test/adcsc_bench.sv ====
// self-checking bench for the sleep-aware converter control
module adc_sleep_control_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0, reset = 1'b1, wr = 1'b0, rd = 1'b0, sleep_exec = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
  logic [11:0] sample_code = 12'h000;
  logic core_asleep, wake_pulse, vector_load, converter_active, irq;
  logic [12:0] program_counter;
  int err_total = 0, check_count = 0, cycles = 0;

  adcsc_top adcsc_top_inst (.core_clk(core_clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .sleep_exec(sleep_exec), .sample_code(sample_code), .rdata(rdata), .core_asleep(core_asleep),
    .wake_pulse(wake_pulse), .vector_load(vector_load), .program_counter(program_counter),
    .converter_active(converter_active), .irq(irq));

  initial begin
    forever #2 core_clk = ~core_clk;
  end

  task wrap_up;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : wrap_up

  // a run that hangs on a lost completion ends here
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 40000) begin
      err_total++;
      wrap_up();
    end
  end

  task chk(input logic [12:0] got, input logic [12:0] exp, input string msg);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask : chk

  task wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask : wr_reg

  task rd_chk(input logic [7:0] a, input logic [7:0] exp, input string msg);
    @(posedge core_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    #1;
    chk({5'h00, rdata}, {5'h00, exp}, msg);
  endtask : rd_chk

  task do_reset;
    @(posedge core_clk);
    reset <= 1'b1;
    repeat (5) @(posedge core_clk);
    reset <= 1'b0;
  endtask : do_reset

  task sleep_now;
    @(posedge core_clk);
    sleep_exec <= 1'b1;
    @(posedge core_clk);
    sleep_exec <= 1'b0;
  endtask : sleep_now

  task automatic t_reset_values;
    logic [7:0] regs [7] = '{8'h0b, 8'h0c, 8'h1f, 8'h8c, 8'h9b, 8'h9f, 8'h55};
    foreach (regs[i]) rd_chk(regs[i], 8'h00, "register not clear after reset");
    wr_reg(8'h9b, 8'hff);
    rd_chk(8'h9b, 8'hf0, "unimplemented reference bits not zero");
    wr_reg(8'h9b, 8'h00);
    $display("test reset_values done");
  endtask : t_reset_values

  task automatic t_clock_divs;
    int n;
    int div [3] = '{2, 8, 32};
    for (int s = 0; s < 3; s++) begin
      sample_code <= 12'h5a3 + 12'(s);
      wr_reg(8'h1f, {2'(s), 6'h05});
      for (n = 0; n < 6 && converter_active !== 1'b1; n++) @(posedge core_clk);
      for (n = 0; n < 500 && converter_active === 1'b1; n++) @(posedge core_clk);
      check_count++;
      if (n < 12 * div[s] - 1 || n > 12 * div[s] + 2) begin
        err_total++;
        $display("BAD %0t conversion length %0d for select %0d", $time, n, s);
      end
      rd_chk(8'h1f, {2'(s), 6'h01}, "start bit not cleared");
      rd_chk(8'h1e, 8'h5a, "high result byte");
      rd_chk(8'h9e, {4'(4'h3 + s), 4'h0}, "low result byte");
      rd_chk(8'h0c, 8'h40, "done flag not set");
      wr_reg(8'h0c, 8'h00);
      rd_chk(8'hf0, 8'h01, "done event missing");
    end
    $display("test clock_divs done");
  endtask : t_clock_divs

  task t_rc_wake;
    int n;
    logic i0;
    wr_reg(8'h9f, 8'h80);
    wr_reg(8'h8c, 8'h40);
    wr_reg(8'h0b, 8'hc0);
    sample_code <= 12'h9c7;
    wr_reg(8'h1f, 8'hc5);
    sleep_now();
    #1;
    chk(converter_active, 1'b0, "rc start not delayed");
    chk(core_asleep, 1'b1, "core not asleep");
    for (n = 0; n < 8 && converter_active !== 1'b1; n++) @(posedge core_clk);
    chk(converter_active, 1'b1, "rc conversion did not start in sleep");
    for (n = 0; n < 3100 && wake_pulse !== 1'b1; n++) begin
      @(posedge core_clk);
      #1;
    end
    chk(wake_pulse, 1'b1, "no wake on completion");
    chk(vector_load, 1'b1, "vector not loaded");
    chk(program_counter, 13'h0004, "vector value");
    repeat (2) @(posedge core_clk);
    #1;
    chk(core_asleep, 1'b0, "core still asleep");
    rd_chk(8'h1e, 8'h09, "right justified high byte");
    rd_chk(8'h9e, 8'hc7, "right justified low byte");
    rd_chk(8'h1f, 8'hc1, "control changed by wake");
    rd_chk(8'h8c, 8'h40, "enables changed by wake");
    rd_chk(8'h0c, 8'h40, "done flag not set");
    wr_reg(8'hf1, 8'h00);
    #1;
    i0 = irq;
    wr_reg(8'hf1, 8'h07);
    #1;
    chk(i0, 1'b0, "irq high with every event masked");
    chk(irq, 1'b1, "irq low with events unmasked");
    rd_chk(8'hf0, 8'h03, "done and wake events");
    @(posedge core_clk);
    #1;
    chk(irq, 1'b0, "irq not cleared by status read");
    wr_reg(8'h0c, 8'h00);
    $display("test rc_wake done");
  endtask : t_rc_wake

  task t_rc_no_irq;
    int n;
    logic woke;
    woke = 1'b0;
    wr_reg(8'h8c, 8'h00);
    sample_code <= 12'h3e1;
    wr_reg(8'h1f, 8'hc5);
    sleep_now();
    repeat (8) @(posedge core_clk);
    for (n = 0; n < 3100 && converter_active === 1'b1; n++) begin
      @(posedge core_clk);
      #1;
      woke |= wake_pulse;
    end
    repeat (4) @(posedge core_clk);
    #1;
    chk(woke | wake_pulse, 1'b0, "woke without enable");
    chk(core_asleep, 1'b1, "core left sleep");
    rd_chk(8'h1f, 8'hc1, "power bit not kept");
    do_reset();
    rd_chk(8'h1e, 8'h03, "high result lost on reset");
    rd_chk(8'h9e, 8'he1, "low result lost on reset");
    rd_chk(8'h9f, 8'h00, "format register not cleared");
    $display("test rc_no_irq done");
  endtask : t_rc_no_irq

  task t_aborts;
    wr_reg(8'h1f, 8'h45);
    repeat (5) @(posedge core_clk);
    #1;
    chk(converter_active, 1'b1, "conversion not running before sleep");
    sleep_now();
    repeat (2) @(posedge core_clk);
    #1;
    chk(converter_active, 1'b0, "sleep did not abort");
    rd_chk(8'h1f, 8'h41, "abort state of control");
    rd_chk(8'hf0, 8'h04, "abort event missing");
    do_reset();
    wr_reg(8'h1f, 8'h85);
    repeat (10) @(posedge core_clk);
    #1;
    chk(converter_active, 1'b1, "conversion not running before reset");
    do_reset();
    #1;
    chk(converter_active, 1'b0, "reset did not abort");
    rd_chk(8'h1f, 8'h00, "reset did not power down");
    $display("test aborts done");
  endtask : t_aborts

  initial begin
    do_reset();
    t_reset_values();
    t_clock_divs();
    t_rc_wake();
    t_rc_no_irq();
    t_aborts();
    wrap_up();
  end
endmodule : adc_sleep_control_tb_top
